// file: rtl/pdu_channel_regs.sv
`include "pdu_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module pdu_channel_regs
   import pdu_pkg::*;
(
   input  wire logic         clk,        // 20 MHz
   input  wire logic         rstn,       // async reset, low
   input  wire logic         psel,       // apb select
   input  wire logic         penable,    // apb access phase
   input  wire logic         pwrite,     // apb direction
   input  wire logic [7:0]   paddr,      // apb byte address
   input  wire logic [31:0]  pwdata,     // apb write data
   output logic              pready,     // apb ready
   output logic [31:0]       prdata,     // apb read data
   output logic              pslverr,    // apb error
   input  wire logic         rx_ready,   // peripheral has rx item
   input  wire logic         tx_ready,   // peripheral wants tx item
   output var pdu_bus_req_s  bus_req,    // matrix request
   input  wire logic         bus_done,   // matrix item moved
   output var pdu_flags_s    flags,      // flags to peripheral
   output logic              rx_on,      // rx requests enabled
   output logic              tx_on       // tx requests enabled
);
   pdu_desc_s  rx_cur_r, tx_cur_r, rx_nxt_r, tx_nxt_r;
   logic       rx_on_r, tx_on_r, half_r;
   pdu_size_e  size_r;
   pdu_state_e state_r;
   pdu_flags_s flags_r;
   logic       wr, rd, ok;
   logic       w_rxc, w_txc, w_rxn, w_txn, w_ctrl;
   logic       rx_go, tx_go, rx_item, tx_item;
   logic       c_rx_on, c_rx_off, c_tx_on, c_tx_off;
   pdu_addr_t  step;
   pdu_desc_s  rx_src, tx_src, rxn_src, txn_src;

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign w_rxc = wr && (paddr == `PDU_OFF_RX_CNT);
   assign w_txc = wr && (paddr == `PDU_OFF_TX_CNT);
   assign w_rxn = wr && (paddr == `PDU_OFF_RXF_CNT);
   assign w_txn = wr && (paddr == `PDU_OFF_TXF_CNT);
   assign w_ctrl = wr && (paddr == `PDU_OFF_CTRL);
   assign c_rx_on = w_ctrl && pwdata[`PDU_BIT_RX_ON];
   assign c_rx_off = w_ctrl && pwdata[`PDU_BIT_RX_OFF];
   assign c_tx_on = w_ctrl && pwdata[`PDU_BIT_TX_ON];
   assign c_tx_off = w_ctrl && pwdata[`PDU_BIT_TX_OFF];

   always_comb begin
      unique case (paddr)
         `PDU_OFF_RX_ADDR, `PDU_OFF_RX_CNT, `PDU_OFF_TX_ADDR,
         `PDU_OFF_TX_CNT, `PDU_OFF_RXF_ADDR, `PDU_OFF_RXF_CNT,
         `PDU_OFF_TXF_ADDR, `PDU_OFF_TXF_CNT, `PDU_OFF_CTRL,
         `PDU_OFF_STAT, `PDU_OFF_MODE, `PDU_OFF_FLAGS: ok = 1'b1;
         default: ok = 1'b0;
      endcase
   end

   // in half duplex the rx copy is the one storage; tx names alias it
   assign rx_src = rx_cur_r;
   assign tx_src = half_r ? rx_cur_r : tx_cur_r;
   assign rxn_src = rx_nxt_r;
   assign txn_src = half_r ? rx_nxt_r : tx_nxt_r;

   always_comb begin
      unique case (size_r)
         PDU_SZ_HALF: step = `PDU_STEP_HALF;
         PDU_SZ_WORD: step = `PDU_STEP_WORD;
         default:     step = `PDU_STEP_BYTE;
      endcase
   end

   // a channel may start only with requests on and count nonzero
   assign rx_go = rx_on_r && (rx_src.cnt != `PDU_CNT_ZERO);
   assign tx_go = tx_on_r && (tx_src.cnt != `PDU_CNT_ZERO);
   assign rx_item = (state_r == PDU_RX_BUS) && bus_done;
   assign tx_item = (state_r == PDU_TX_BUS) && bus_done;

   // apb: zero wait states, error on unmapped address
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `PDU_ADDR_ZERO;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !ok;
         prdata  <= `PDU_ADDR_ZERO;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               `PDU_OFF_RX_ADDR:  prdata <= rx_src.addr;
               `PDU_OFF_RX_CNT:   prdata <= {16'h0000, rx_src.cnt};
               `PDU_OFF_TX_ADDR:  prdata <= tx_src.addr;
               `PDU_OFF_TX_CNT:   prdata <= {16'h0000, tx_src.cnt};
               `PDU_OFF_RXF_ADDR: prdata <= rxn_src.addr;
               `PDU_OFF_RXF_CNT:  prdata <= {16'h0000, rxn_src.cnt};
               `PDU_OFF_TXF_ADDR: prdata <= txn_src.addr;
               `PDU_OFF_TXF_CNT:  prdata <= {16'h0000, txn_src.cnt};
               `PDU_OFF_STAT: begin
                  prdata[`PDU_BIT_RX_ON] <= rx_on_r;
                  prdata[`PDU_BIT_TX_ON] <= tx_on_r;
               end
               `PDU_OFF_MODE: begin
                  prdata[`PDU_BIT_HALF] <= half_r;
                  prdata[`PDU_BIT_SIZE_HI:`PDU_BIT_SIZE_LO] <= size_r;
               end
               `PDU_OFF_FLAGS: begin
                  prdata[`PDU_BIT_RX_DONE] <= flags_r.rx_block_done_flag;
                  prdata[`PDU_BIT_RX_ALL]
                     <= flags_r.rx_all_buffers_done_flag;
                  prdata[`PDU_BIT_TX_DONE] <= flags_r.tx_block_done_flag;
                  prdata[`PDU_BIT_TX_ALL]
                     <= flags_r.tx_all_buffers_done_flag;
               end
               default: prdata <= `PDU_ADDR_ZERO;
            endcase
         end
      end
   end

   // mode register; a write takes effect at any time, whatever the channel enables
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         half_r <= 1'b0;
         size_r <= PDU_SZ_BYTE;
      end else if (wr && paddr == `PDU_OFF_MODE) begin
         half_r <= pwdata[`PDU_BIT_HALF];
         size_r <= pdu_size_e'(pwdata[`PDU_BIT_SIZE_HI:`PDU_BIT_SIZE_LO]);
      end
   end

   // enables: off bits win over on bits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_on_r <= 1'b0;
         tx_on_r <= 1'b0;
      end else if (w_ctrl) begin
         if (half_r) begin
            if (c_rx_off || c_tx_off) begin
               rx_on_r <= 1'b0;
               tx_on_r <= 1'b0;
            end else if (c_rx_on) begin
               rx_on_r <= 1'b1;
               tx_on_r <= 1'b0;
            end else if (c_tx_on) begin
               tx_on_r <= 1'b1;
            end
         end else begin
            if (c_rx_off)
               rx_on_r <= 1'b0;
            else if (c_rx_on)
               rx_on_r <= 1'b1;
            if (c_tx_off)
               tx_on_r <= 1'b0;
            else if (c_tx_on)
               tx_on_r <= 1'b1;
         end
      end
   end

   // bus sequencer: one item at a time, rx served first
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= PDU_IDLE;
      end else begin
         unique case (state_r)
            PDU_IDLE:
               if (rx_go && rx_ready)
                  state_r <= PDU_RX_BUS;
               else if (tx_go && tx_ready)
                  state_r <= PDU_TX_BUS;
            PDU_RX_BUS, PDU_TX_BUS:
               if (bus_done)
                  state_r <= PDU_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_req <= '0;
      end else begin
         bus_req.valid <= 1'b0;
         bus_req.size  <= size_r;
         if (state_r == PDU_IDLE && rx_go && rx_ready) begin
            bus_req.valid <= 1'b1;
            bus_req.write <= 1'b1;
            bus_req.addr  <= rx_src.addr;
         end else if (state_r == PDU_IDLE && tx_go && tx_ready) begin
            bus_req.valid <= 1'b1;
            bus_req.write <= 1'b0;
            bus_req.addr  <= tx_src.addr;
         end else if (state_r != PDU_IDLE && !bus_done) begin
            bus_req.valid <= 1'b1;
         end
      end
   end

   // descriptors; software write beats a same-cycle hardware update
   generate
      for (genvar d = 0; d < 2; d++) begin : g_dir
         pdu_desc_s cur_nxt, fol_nxt;
         logic      item;
         logic [7:0] o_ca, o_cc, o_fa, o_fc;
         pdu_desc_s  cur_q, fol_q;
         logic       hit, shared;
         assign o_ca = d ? `PDU_OFF_TX_ADDR  : `PDU_OFF_RX_ADDR;
         assign o_cc = d ? `PDU_OFF_TX_CNT   : `PDU_OFF_RX_CNT;
         assign o_fa = d ? `PDU_OFF_TXF_ADDR : `PDU_OFF_RXF_ADDR;
         assign o_fc = d ? `PDU_OFF_TXF_CNT  : `PDU_OFF_RXF_CNT;
         assign item = d ? (tx_item && !half_r)
                         : (rx_item || (half_r && tx_item));
         assign cur_q = d ? tx_cur_r : rx_cur_r;
         assign fol_q = d ? tx_nxt_r : rx_nxt_r;
         // half duplex routes tx writes to the shared rx copy
         assign hit = d ? !half_r : 1'b1;
         assign shared = (d == 0) && half_r;
         always_comb begin
            cur_nxt = cur_q;
            fol_nxt = fol_q;
            if (item) begin
               cur_nxt.addr = cur_q.addr + step;
               cur_nxt.cnt  = cur_q.cnt - `PDU_CNT_ONE;
               if (cur_q.cnt == `PDU_CNT_ONE &&
                   fol_q.cnt != `PDU_CNT_ZERO) begin
                  cur_nxt = fol_q;
                  fol_nxt = '0;
               end
            end
            if (wr && (hit || d == 0)) begin
               if (paddr == o_ca || (shared && paddr == `PDU_OFF_TX_ADDR))
                  cur_nxt.addr = pwdata;
               if (paddr == o_cc || (shared && paddr == `PDU_OFF_TX_CNT))
                  cur_nxt.cnt = pwdata[15:0];
               if (paddr == o_fa || (shared && paddr == `PDU_OFF_TXF_ADDR))
                  fol_nxt.addr = pwdata;
               if (paddr == o_fc || (shared && paddr == `PDU_OFF_TXF_CNT))
                  fol_nxt.cnt = pwdata[15:0];
            end
         end
         if (d == 0) begin : g_rx
            always_ff @(posedge clk or negedge rstn) begin
               if (!rstn) begin
                  rx_cur_r <= '0;
                  rx_nxt_r <= '0;
               end else begin
                  rx_cur_r <= cur_nxt;
                  rx_nxt_r <= fol_nxt;
               end
            end
         end else begin : g_tx
            always_ff @(posedge clk or negedge rstn) begin
               if (!rstn) begin
                  tx_cur_r <= '0;
                  tx_nxt_r <= '0;
               end else begin
                  tx_cur_r <= cur_nxt;
                  tx_nxt_r <= fol_nxt;
               end
            end
         end
      end
   endgenerate

   // flags: set by the last item, cleared by nonzero count writes;
   // set wins when both land in one cycle
   logic rx_last, tx_last, rx_clr, tx_clr;
   assign rx_last = rx_item && rx_src.cnt == `PDU_CNT_ONE;
   assign tx_last = tx_item && tx_src.cnt == `PDU_CNT_ONE;
   assign rx_clr = (w_rxc || w_rxn) && pwdata[15:0] != `PDU_CNT_ZERO;
   assign tx_clr = (w_txc || w_txn) && pwdata[15:0] != `PDU_CNT_ZERO;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags_r <= '0;
      end else begin
         if (rx_last)
            flags_r.rx_block_done_flag <= 1'b1;
         else if (rx_clr || (half_r && tx_clr))
            flags_r.rx_block_done_flag <= 1'b0;
         if (rx_last && rxn_src.cnt == `PDU_CNT_ZERO)
            flags_r.rx_all_buffers_done_flag <= 1'b1;
         else if (rx_clr || (half_r && tx_clr))
            flags_r.rx_all_buffers_done_flag <= 1'b0;
         if (tx_last)
            flags_r.tx_block_done_flag <= 1'b1;
         else if (tx_clr || (half_r && rx_clr))
            flags_r.tx_block_done_flag <= 1'b0;
         if (tx_last && txn_src.cnt == `PDU_CNT_ZERO)
            flags_r.tx_all_buffers_done_flag <= 1'b1;
         else if (tx_clr || (half_r && rx_clr))
            flags_r.tx_all_buffers_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags <= '0;
         rx_on <= 1'b0;
         tx_on <= 1'b0;
      end else begin
         flags <= flags_r;
         rx_on <= rx_on_r;
         tx_on <= tx_on_r;
      end
   end
endmodule
`default_nettype wire

// file: rtl/pdu_consts.svh
`ifndef PDU_CONSTS_SVH
`define PDU_CONSTS_SVH
`define PDU_OFF_RX_ADDR   8'h00
`define PDU_OFF_RX_CNT    8'h04
`define PDU_OFF_TX_ADDR   8'h08
`define PDU_OFF_TX_CNT    8'h0c
`define PDU_OFF_RXF_ADDR  8'h10
`define PDU_OFF_RXF_CNT   8'h14
`define PDU_OFF_TXF_ADDR  8'h18
`define PDU_OFF_TXF_CNT   8'h1c
`define PDU_OFF_CTRL      8'h20
`define PDU_OFF_STAT      8'h24
`define PDU_OFF_MODE      8'h28
`define PDU_OFF_FLAGS     8'h2c
`define PDU_BIT_RX_ON     0
`define PDU_BIT_RX_OFF    1
`define PDU_BIT_TX_ON     8
`define PDU_BIT_TX_OFF    9
`define PDU_BIT_HALF      0
`define PDU_BIT_SIZE_LO   4
`define PDU_BIT_SIZE_HI   5
`define PDU_BIT_RX_DONE   0
`define PDU_BIT_RX_ALL    1
`define PDU_BIT_TX_DONE   2
`define PDU_BIT_TX_ALL    3
`define PDU_CNT_ZERO      16'h0000
`define PDU_CNT_ONE       16'h0001
`define PDU_ADDR_ZERO     32'h0000_0000
`define PDU_STEP_BYTE     32'h0000_0001
`define PDU_STEP_HALF     32'h0000_0002
`define PDU_STEP_WORD     32'h0000_0004
`endif

// file: rtl/pdu_pkg.sv
package pdu_pkg;
   typedef logic [31:0] pdu_addr_t;
   typedef logic [15:0] pdu_cnt_t;
   typedef enum logic [1:0] {
      PDU_SZ_BYTE,
      PDU_SZ_HALF,
      PDU_SZ_WORD,
      PDU_SZ_RSVD
   } pdu_size_e;
   typedef enum {
      PDU_IDLE,
      PDU_RX_BUS,
      PDU_TX_BUS
   } pdu_state_e;
   // one buffer descriptor: where and how many
   typedef struct packed {
      pdu_addr_t addr;
      pdu_cnt_t  cnt;
   } pdu_desc_s;
   // request to the bus matrix
   typedef struct packed {
      logic      valid;
      logic      write;
      pdu_addr_t addr;
      pdu_size_e size;
   } pdu_bus_req_s;
   // flags back to the serial peripheral
   typedef struct packed {
      logic rx_block_done_flag;
      logic rx_all_buffers_done_flag;
      logic tx_block_done_flag;
      logic tx_all_buffers_done_flag;
   } pdu_flags_s;
endpackage

// file: sim/pdu_channel_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module pdu_channel_regs_props
   import pdu_pkg::*;
(
   input wire logic         clk,      // clock
   input wire logic         rstn,     // reset, low
   input wire logic         psel,     // apb select
   input wire logic         penable,  // apb access
   input wire logic         pwrite,   // apb direction
   input wire logic [7:0]   paddr,    // apb address
   input wire logic [31:0]  pwdata,   // apb write data
   input wire logic         pready,   // apb ready
   input wire logic [31:0]  prdata,   // apb read data
   input wire logic         pslverr,  // apb error
   input wire logic         rx_ready, // peripheral rx
   input wire logic         tx_ready, // peripheral tx
   input wire pdu_bus_req_s bus_req,  // matrix request
   input wire logic         bus_done, // matrix done
   input wire pdu_flags_s   flags,    // peripheral flags
   input wire logic         rx_on,    // rx enabled
   input wire logic         tx_on     // tx enabled
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   a_req_needs_on: assert property ($rose(bus_req.valid) |->
      (bus_req.write ? rx_on && $past(rx_ready) : tx_on && $past(tx_ready)))
      else $error("request without enable or ready");
   a_req_held: assert property (bus_req.valid && !bus_done |=>
      bus_req.valid && $stable(bus_req.addr) && $stable(bus_req.write))
      else $error("request dropped or changed before done");
   a_one_outstanding: assert property (bus_done |=> !bus_req.valid)
      else $error("request still up after done");
   a_ready_waitfree: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
   a_unmapped_err: assert property (psel && penable && paddr[7:2] > 6'hb
      |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
   a_ctrl_reads_zero: assert property (pready && !pwrite && paddr == 8'h20
      |-> prdata == 32'h0) else $error("control read not zero");
   a_count_upper: assert property (pready && !pwrite && paddr[2]
      && paddr < 8'h20 |-> prdata[31:16] == 16'h0)
      else $error("count upper bits not zero");
   a_stat_unused: assert property (pready && !pwrite && paddr == 8'h24
      |-> prdata[31:9] == 23'h0 && prdata[7:1] == 7'h0)
      else $error("status unused bits set");
   a_rx_off_wins: assert property (psel && penable && pwrite
      && paddr == 8'h20 && pwdata[1] |-> ##[1:2] !rx_on)
      else $error("rx still on after disable");
   a_tx_off_wins: assert property (psel && penable && pwrite
      && paddr == 8'h20 && pwdata[9] |-> ##[1:2] !tx_on)
      else $error("tx still on after disable");
endmodule
bind pdu_channel_regs pdu_channel_regs_props pdu_channel_regs_props_i (
   .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .rx_ready(rx_ready), .tx_ready(tx_ready),
   .bus_req(bus_req), .bus_done(bus_done), .flags(flags), .rx_on(rx_on),
   .tx_on(tx_on));
`default_nettype wire

// file: sim/pdu_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pdu_partner
   import pdu_pkg::*;
(
   input wire logic         clk,        // clock
   input wire logic         rstn,       // reset, low
   input wire pdu_bus_req_s bus_req,    // request seen
   input wire logic [3:0]   lag,        // extra wait cycles
   output logic             bus_done,   // item moved
   output logic [15:0]      items,      // items moved
   output var pdu_addr_t    last_addr,  // last item address
   output logic             last_write  // last item direction
);
   logic [3:0] wait_r;
   // a slow grant keeps the request standing several cycles
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_done   <= 1'b0;
         wait_r     <= 4'h0;
         items      <= 16'h0;
         last_addr  <= 32'h0;
         last_write <= 1'b0;
      end else begin
         bus_done <= 1'b0;
         if (bus_req.valid && !bus_done && wait_r >= lag) begin
            bus_done   <= 1'b1;
            wait_r     <= 4'h0;
            items      <= items + 16'h1;
            last_addr  <= bus_req.addr;
            last_write <= bus_req.write;
         end else if (bus_req.valid && !bus_done)
            wait_r <= wait_r + 4'h1;
      end
   end
endmodule
`default_nettype wire

// file: sim/pdu_channel_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pdu_channel_regs_bench
   import pdu_pkg::*;
;
   logic         clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic         pwrite = 1'b0, rx_ready = 1'b0, tx_ready = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0, prdata, rd;
   logic         pready, pslverr, slv, bus_done, last_write, rx_on, tx_on;
   logic [3:0]   lag = 4'h0;
   logic [15:0]  items;
   pdu_addr_t    last_addr;
   pdu_bus_req_s bus_req;
   pdu_flags_s   flags;
   int           err_total = 0, checks_done = 0;
   // control writes and the status each one must leave; half duplex from 6
   logic [31:0]  cw [12] = '{32'h3, 32'h1, 32'h100, 32'h0, 32'h2, 32'h200,
                             32'h100, 32'h1, 32'h200, 32'h100, 32'h2, 32'h1};
   logic [31:0]  cs [12] = '{32'h0, 32'h1, 32'h101, 32'h101, 32'h100, 32'h0,
                             32'h100, 32'h1, 32'h0, 32'h100, 32'h0, 32'h1};
   always #25 clk = ~clk;
   pdu_channel_regs pdu_channel_regs_i (.clk(clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .rx_ready(rx_ready), .tx_ready(tx_ready), .bus_req(bus_req),
      .bus_done(bus_done), .flags(flags), .rx_on(rx_on), .tx_on(tx_on));
   pdu_partner pdu_partner_i (.clk(clk), .rstn(rstn), .bus_req(bus_req),
      .lag(lag), .bus_done(bus_done), .items(items), .last_addr(last_addr),
      .last_write(last_write));
   task automatic stop_test;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         err_total++;
         stop_test;
      end
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, string nm);
      apb(1'b0, a, 32'h0);
      check(nm, rd, e);
   endtask
   task automatic wait_items(input logic [15:0] e);
      int n;
      n = 0;
      while (items !== e && n < 300) begin
         @(posedge clk);
         n++;
      end
      check("items", {16'h0, items}, {16'h0, e});
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 10; i++)
         rdc(8'(4 * i), 32'h0, "reset value");
      apb(1'b1, 8'h0c, 32'hffff_0003);
      rdc(8'h0c, 32'h3, "tx count");
      apb(1'b1, 8'h1c, 32'h7);
      rdc(8'h1c, 32'h7, "tx next count");
      rdc(8'h20, 32'h0, "control");
      for (int i = 0; i < 12; i++) begin
         if (i == 6)
            apb(1'b1, 8'h28, 32'h1);
         apb(1'b1, 8'h20, cw[i]);
         rdc(8'h24, cs[i], "status");
         check("enables", {23'h0, tx_on, 7'h0, rx_on}, cs[i]);
      end
      apb(1'b1, 8'h00, 32'h5000);
      rdc(8'h08, 32'h5000, "shared addr");
      apb(1'b1, 8'h0c, 32'h9);
      rdc(8'h04, 32'h9, "shared count");
      apb(1'b1, 8'h10, 32'h6000);
      rdc(8'h18, 32'h6000, "shared next addr");
      apb(1'b1, 8'h1c, 32'h8);
      rdc(8'h14, 32'h8, "shared next count");
      apb(1'b1, 8'h28, 32'h0);
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h20, 32'h1);
      rx_ready <= 1'b1;
      repeat (10) @(posedge clk);
      check("items", {16'h0, items}, 32'h0);
      rx_ready <= 1'b0;
      apb(1'b1, 8'h00, 32'h1000);
      apb(1'b1, 8'h04, 32'h2);
      apb(1'b1, 8'h10, 32'h3000);
      apb(1'b1, 8'h14, 32'h1);
      rx_ready <= 1'b1;
      wait_items(16'h3);
      rx_ready <= 1'b0;
      check("last addr", last_addr, 32'h3000);
      check("direction", {31'h0, last_write}, 32'h1);
      rdc(8'h00, 32'h3001, "rx addr");
      rdc(8'h14, 32'h0, "rx next count");
      rdc(8'h2c, 32'h3, "flags");
      apb(1'b1, 8'h04, 32'h1);
      repeat (2) @(posedge clk);
      check("rx done", {31'h0, flags.rx_block_done_flag}, 32'h0);
      apb(1'b1, 8'h20, 32'h2);
      lag <= 4'h3;
      apb(1'b1, 8'h28, 32'h20);
      apb(1'b1, 8'h08, 32'h2000_0000);
      apb(1'b1, 8'h0c, 32'h3);
      apb(1'b1, 8'h1c, 32'h0);
      apb(1'b1, 8'h20, 32'h100);
      tx_ready <= 1'b1;
      wait_items(16'h6);
      repeat (10) @(posedge clk);
      check("items", {16'h0, items}, 32'h6);
      tx_ready <= 1'b0;
      check("size", {30'h0, bus_req.size}, 32'h2);
      check("last addr", last_addr, 32'h2000_0008);
      check("direction", {31'h0, last_write}, 32'h0);
      rdc(8'h08, 32'h2000_000c, "tx addr");
      apb(1'b0, 8'h2c, 32'h0);
      check("tx flags", rd & 32'hc, 32'hc);
      check("tx pins", {28'h0, flags}, 32'h3);
      apb(1'b0, 8'h30, 32'h0);
      check("slave error", {31'h0, slv}, 32'h1);
      apb(1'b1, 8'h24, 32'hffff_ffff);
      rdc(8'h24, 32'h100, "status");
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test;
   end
endmodule
`default_nettype wire
